/* File: verilog/ssm_port.v */
// Top of the synchronous serial port: AHB-Lite registers, transmit path, slave shifting.
// Assumes a single AHB-Lite master; pins are split into input, output and enable.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_port
(
   input wire CLK_IN,
   input wire RST_IN,
   input wire HSEL_IN,
   input wire [31:0] HADDR_IN,
   input wire [1:0] HTRANS_IN,
   input wire HWRITE_IN,
   input wire [2:0] HSIZE_IN,
   input wire [31:0] HWDATA_IN,
   input wire HREADY_IN,
   output reg [31:0] HRDATA_OUT,
   output reg HREADYOUT_OUT,
   output reg HRESP_OUT,
   input wire DATA_PIN_IN,
   output reg DATA_PIN_OUT,
   output reg DATA_PIN_OE_OUT,
   input wire CLOCK_PIN_IN,
   output reg CLOCK_PIN_OUT,
   output reg CLOCK_PIN_OE_OUT,
   output reg IRQ_OUT
);
   localparam ST_IDLE = 2'b00;
   localparam ST_LEAD = 2'b01;
   localparam ST_TRAIL = 2'b10;
   reg [7:0] txctl;
   reg [7:0] rxctl;
   reg [7:0] baudctl;
   reg [7:0] div_lo;
   reg [7:0] div_hi;
   reg [7:0] hold;
   reg hold_ninth;
   reg hold_full;
   reg [7:0] intctl;
   reg [7:0] peripheral_interrupt_enable_1;
   reg [8:0] transmit_shift_reg;
   reg [3:0] bits_left;
   reg [1:0] state;
   reg [7:0] rx_shift;
   reg [7:0] rx_data;
   reg [3:0] rx_count;
   reg ck_prev;
   reg wr_pend;
   reg [7:0] wr_addr;
   reg [7:0] rd_word;
   wire tick;
   wire ck_sync;
   wire dt_sync;
   wire sync_mode;
   wire master;
   wire enabled;
   wire rx_req;
   wire tx_mode;
   wire slave_mode;
   wire lead_level;
   wire idle_level;
   wire txif;
   wire addr_phase;
   wire hold_write;
   wire load_tsr;
   wire ck_edge_lead;
   wire ck_edge_trail;
   wire [7:0] rd_addr;
   ssm_sync2 u_ck_sync
   (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .d_in(CLOCK_PIN_IN),
      .q_out(ck_sync)
   );
   ssm_sync2 u_dt_sync
   (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .d_in(DATA_PIN_IN),
      .q_out(dt_sync)
   );
   ssm_baud u_baud
   (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .run_in(state != ST_IDLE),
      .divisor_in({div_hi, div_lo}),
      .wide_in(baudctl[`SSM_B_BAUD_WIDE_DIVIDER]),
      .high_speed_in(baudctl[`SSM_B_BAUD_HIGH_SPEED]),
      .tick_out(tick)
   );
   assign sync_mode = txctl[`SSM_B_SYNC];
   assign master = txctl[`SSM_B_CLOCK_SOURCE_MASTER];
   assign enabled = rxctl[`SSM_B_PORT_ENABLE] && sync_mode;
   assign rx_req = rxctl[`SSM_B_SINGLE_RECEIVE_ENABLE] | rxctl[`SSM_B_CONTINUOUS_RECEIVE_ENABLE];
   // transmit is held off while a receive is requested
   assign tx_mode = enabled && !rx_req && txctl[`SSM_B_TRANSMIT_ENABLE];
   assign slave_mode = enabled && !master;
   assign idle_level = baudctl[`SSM_B_CLOCK_IDLE_POLARITY];
   assign lead_level = ~idle_level;
   // flag while holding register free
   // The flag ignores the mode: a character written now waits until it is sent.
   assign txif = !hold_full;
   assign addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN == `SSM_HTRANS_NONSEQ;
   assign rd_addr = HADDR_IN[7:0];
   assign hold_write = wr_pend && wr_addr == `SSM_A_HOLD;
   assign load_tsr = hold_full && tx_mode && state == ST_IDLE && master;
   // external clock edges in slave mode
   assign ck_edge_lead = slave_mode && ck_prev == idle_level && ck_sync == lead_level;
   assign ck_edge_trail = slave_mode && ck_prev == lead_level && ck_sync == idle_level;
   // Reads decode the address phase itself, so the word stands in the data phase.
   // shift register not in read map
   always @*
   begin
      case (rd_addr)
         `SSM_A_TXCTL: rd_word = {txctl[7:2], bits_left == 4'h0, txctl[0]};
         `SSM_A_RXCTL: rd_word = rxctl;
         `SSM_A_BAUDCTL: rd_word = baudctl;
         `SSM_A_DIVLO: rd_word = div_lo;
         `SSM_A_DIVHI: rd_word = div_hi;
         `SSM_A_HOLD: rd_word = rx_data;
         `SSM_A_INTCTL: rd_word = intctl;
         `SSM_A_PERIPHERAL_INTERRUPT_ENABLE_1: rd_word = peripheral_interrupt_enable_1;
         `SSM_A_PERIPHERAL_INTERRUPT_FLAG_1: rd_word = {3'b000, txif, 4'h0};
         default: rd_word = 8'h00;
      endcase
   end
   // The slave answers in zero wait states, so HREADYOUT stays high.
   always @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         HRDATA_OUT <= 32'h00000000;
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
      end
      else
      begin
         HREADYOUT_OUT <= 1'b1;
         HRESP_OUT <= 1'b0;
         if (HREADY_IN)
         begin
            wr_pend <= addr_phase && HWRITE_IN;
            wr_addr <= addr_phase ? HADDR_IN[7:0] : 8'hff;
         end
         // Read data is launched at the address phase and stands for one cycle.
         if (addr_phase && !HWRITE_IN)
            HRDATA_OUT <= {24'h000000, rd_word};
         else
            HRDATA_OUT <= 32'h00000000;
      end
   end
   always @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         txctl <= `SSM_RST_BYTE;
         rxctl <= `SSM_RST_BYTE;
         baudctl <= `SSM_RST_BYTE;
         div_lo <= `SSM_RST_BYTE;
         div_hi <= `SSM_RST_BYTE;
         intctl <= `SSM_RST_BYTE;
         peripheral_interrupt_enable_1 <= `SSM_RST_BYTE;
         hold <= `SSM_RST_BYTE;
         hold_ninth <= 1'b0;
         hold_full <= 1'b0;
      end
      else
      begin
         if (wr_pend)
         begin
            case (wr_addr)
               `SSM_A_TXCTL: txctl <= HWDATA_IN[7:0];
               `SSM_A_RXCTL: rxctl <= HWDATA_IN[7:0];
               `SSM_A_BAUDCTL: baudctl <= HWDATA_IN[7:0];
               `SSM_A_DIVLO: div_lo <= HWDATA_IN[7:0];
               `SSM_A_DIVHI: div_hi <= HWDATA_IN[7:0];
               `SSM_A_INTCTL: intctl <= HWDATA_IN[7:0];
               `SSM_A_PERIPHERAL_INTERRUPT_ENABLE_1: peripheral_interrupt_enable_1 <= HWDATA_IN[7:0];
               default: hold <= hold;
            endcase
         end
         // A write in the cycle of a load keeps the flag set, so no character is lost.
         // character waits in holding register
         if (hold_write)
         begin
            hold <= HWDATA_IN[7:0];
            // ninth bit captured with the character
            hold_ninth <= txctl[`SSM_B_NINTH_BIT_VALUE];
            hold_full <= 1'b1;
         end
         else if (load_tsr)
            hold_full <= 1'b0;
      end
   end
   // Master transmit engine; each tick is half a bit period.
   always @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         state <= ST_IDLE;
         transmit_shift_reg <= 9'h000;
         bits_left <= 4'h0;
         CLOCK_PIN_OUT <= 1'b0;
         DATA_PIN_OUT <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               // Between frames the clock rests at its idle level.
               CLOCK_PIN_OUT <= idle_level;
               if (load_tsr)
               begin
                  transmit_shift_reg <= {hold_ninth, hold};
                  bits_left <= txctl[`SSM_B_TX9] ? 4'h9 : 4'h8;
                  // first bit placed with the leading edge
                  DATA_PIN_OUT <= hold[0];
                  CLOCK_PIN_OUT <= lead_level;
                  state <= ST_LEAD;
               end
            end
            ST_LEAD:
            begin
               if (tick)
               begin
                  CLOCK_PIN_OUT <= idle_level;
                  state <= ST_TRAIL;
               end
            end
            ST_TRAIL:
            begin
               if (tick)
               begin
                  if (bits_left == 4'h1)
                  begin
                     bits_left <= 4'h0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
                     DATA_PIN_OUT <= transmit_shift_reg[1];
                     CLOCK_PIN_OUT <= lead_level;
                     bits_left <= bits_left - 4'h1;
                     state <= ST_LEAD;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // Slave receive shifting on the external clock's trailing edge.
   always @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         ck_prev <= 1'b0;
         rx_shift <= 8'h00;
         rx_data <= 8'h00;
         rx_count <= 4'h0;
      end
      else
      begin
         ck_prev <= ck_sync;
         if (ck_edge_trail && rx_req)
         begin
            rx_shift <= {dt_sync, rx_shift[7:1]};
            if (rx_count == 4'h7)
            begin
               rx_data <= {dt_sync, rx_shift[7:1]};
               rx_count <= 4'h0;
            end
            else
               rx_count <= rx_count + 4'h1;
         end
         // A leading edge outside a receive drops any partial byte.
         else if (ck_edge_lead && !rx_req)
            rx_count <= 4'h0;
      end
   end
   always @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         CLOCK_PIN_OE_OUT <= 1'b0;
         DATA_PIN_OE_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
      end
      else
      begin
         CLOCK_PIN_OE_OUT <= enabled && master;
         // data driver only in master transmit
         DATA_PIN_OE_OUT <= tx_mode && master;
         // The pin also waits for transmit mode, so a receiving port stays quiet.
         // three enables gate the interrupt
         IRQ_OUT <= txif && tx_mode && peripheral_interrupt_enable_1[`SSM_B_TRANSMIT_IRQ_ENABLE] && intctl[`SSM_B_GIE] &&
            intctl[`SSM_B_PERIPHERAL_IRQ_ENABLE];
      end
   end
endmodule // ssm_port

/* File: include/ssm_map.vh */
// Register map, field positions and reset values of the synchronous serial port.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef SSM_MAP_VH
`define SSM_MAP_VH
`define SSM_A_TXCTL 8'h00
`define SSM_A_RXCTL 8'h04
`define SSM_A_BAUDCTL 8'h08
`define SSM_A_DIVLO 8'h0c
`define SSM_A_DIVHI 8'h10
`define SSM_A_HOLD 8'h14
`define SSM_A_INTCTL 8'h18
`define SSM_A_PERIPHERAL_INTERRUPT_ENABLE_1 8'h1c
`define SSM_A_PERIPHERAL_INTERRUPT_FLAG_1 8'h20
`define SSM_B_NINTH_BIT_VALUE 0
`define SSM_B_SYNC 4
`define SSM_B_TRANSMIT_ENABLE 5
`define SSM_B_TX9 6
`define SSM_B_CLOCK_SOURCE_MASTER 7
`define SSM_B_CONTINUOUS_RECEIVE_ENABLE 4
`define SSM_B_SINGLE_RECEIVE_ENABLE 5
`define SSM_B_PORT_ENABLE 7
`define SSM_B_BAUD_WIDE_DIVIDER 3
`define SSM_B_CLOCK_IDLE_POLARITY 4
`define SSM_B_BAUD_HIGH_SPEED 2
`define SSM_B_TRANSMIT_IRQ_ENABLE 4
`define SSM_B_TXIF 4
`define SSM_B_PERIPHERAL_IRQ_ENABLE 6
`define SSM_B_GIE 7
`define SSM_B_TSR_EMPTY 1
`define SSM_RST_BYTE 8'h00
`define SSM_HTRANS_NONSEQ 2'b10
`define SSM_DIV_PRE_BITS 2
`endif

/* File: verilog/ssm_sync2.v */
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a plain level; no pulse shorter than a clock is caught.
`timescale 1ns/1ps
module ssm_sync2
(
   input wire clk_in,
   input wire rst_in,
   input wire d_in,
   output reg q_out
);
   reg stage1;
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         stage1 <= 1'b0;
         q_out <= 1'b0;
      end
      else
      begin
         stage1 <= d_in;
         q_out <= stage1;
      end
   end
endmodule // ssm_sync2

/* File: verilog/ssm_baud.v */
// Baud tick generator: one tick per half bit period of the shift clock.
// Assumes the divisor is stable while a character is shifted.
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_baud
(
   input wire clk_in,
   input wire rst_in,
   input wire run_in,
   input wire [15:0] divisor_in,
   input wire wide_in,
   input wire high_speed_in,
   output reg tick_out
);
   reg [17:0] count;
   wire [15:0] div_used;
   wire [17:0] limit;
   assign div_used = wide_in ? divisor_in : {8'h00, divisor_in[7:0]};
   // Low speed stretches the period fourfold; high speed uses the divisor plainly.
   assign limit = high_speed_in ? {2'b00, div_used} : {div_used, 2'b11};
   always @(posedge clk_in)
   begin
      if (rst_in || !run_in)
      begin
         count <= 18'h00000;
         tick_out <= 1'b0;
      end
      else if (count >= limit)
      begin
         count <= 18'h00000;
         tick_out <= 1'b1;
      end
      else
      begin
         count <= count + 18'h00001;
         tick_out <= 1'b0;
      end
   end
endmodule // ssm_baud

/* File: test/ssm_port_monitor.sv */
// Checker of the port's bus answers and pin behaviour, bound into the top module.
// Assumes the bus writes it watches are the only source of configuration.
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_port_monitor
(
   input wire CLK_IN,
   input wire RST_IN,
   input wire HSEL_IN,
   input wire [31:0] HADDR_IN,
   input wire [1:0] HTRANS_IN,
   input wire HWRITE_IN,
   input wire [31:0] HWDATA_IN,
   input wire HREADY_IN,
   input wire [31:0] HRDATA_OUT,
   input wire HREADYOUT_OUT,
   input wire HRESP_OUT,
   input wire DATA_PIN_OUT,
   input wire DATA_PIN_OE_OUT,
   input wire CLOCK_PIN_OUT,
   input wire CLOCK_PIN_OE_OUT,
   input wire IRQ_OUT
);
   reg [31:0] wa;
   reg wp, pol, ms;
   reg [2:0] en;
   wire ap = HSEL_IN && HREADY_IN && HTRANS_IN == `SSM_HTRANS_NONSEQ;
   // Shadow copies of the fields that the properties depend on.
   always @(posedge CLK_IN)
   begin
      wa <= HADDR_IN;
      if (RST_IN)
      begin
         wp <= 1'b0;
         pol <= 1'b0;
         ms <= 1'b0;
         en <= 3'h0;
      end
      else
      begin
         wp <= ap && HWRITE_IN;
         if (wp && wa[7:0] == `SSM_A_BAUDCTL)
            pol <= HWDATA_IN[4];
         if (wp && wa[7:0] == `SSM_A_TXCTL)
            ms <= HWDATA_IN[7];
         if (wp && wa[7:0] == `SSM_A_INTCTL)
            en[1:0] <= HWDATA_IN[7:6];
         if (wp && wa[7:0] == `SSM_A_PERIPHERAL_INTERRUPT_ENABLE_1)
            en[2] <= HWDATA_IN[4];
      end
   end
   default clocking dc @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
      else $error("bus answer not ready or not okay");
   a_oe_pair: assert property (DATA_PIN_OE_OUT && ms |-> CLOCK_PIN_OE_OUT)
      else $error("data driven without clock driver");
   a_data_on_lead: assert property (DATA_PIN_OE_OUT && $past(DATA_PIN_OE_OUT)
      && $changed(DATA_PIN_OUT) |-> $changed(CLOCK_PIN_OUT) && CLOCK_PIN_OUT != pol)
      else $error("data moved off the leading edge");
   a_idle_level: assert property ($rose(CLOCK_PIN_OE_OUT) |-> CLOCK_PIN_OUT == pol)
      else $error("clock does not start at idle level");
   a_irq_enables: assert property (IRQ_OUT |-> $past(en) == 3'h7)
      else $error("interrupt without all enables");
   a_reset_quiet: assert property (disable iff (1'b0) RST_IN
      |=> !DATA_PIN_OE_OUT && !CLOCK_PIN_OE_OUT && !IRQ_OUT)
      else $error("pins driven during reset");
   a_upper_zero: assert property (ap && !HWRITE_IN |=> HRDATA_OUT[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   a_unmapped_zero: assert property (ap && !HWRITE_IN && HADDR_IN > 32'h20
      |=> HRDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   cover property (IRQ_OUT);
   cover property ($rose(CLOCK_PIN_OE_OUT));
   cover property (DATA_PIN_OE_OUT && $changed(DATA_PIN_OUT));
endmodule // ssm_port_monitor
bind ssm_port ssm_port_monitor ssm_port_monitor_inst (.*);

/* File: test/ssm_slave_model.sv */
// Synchronous slave that listens to the shared clock and data lines.
// Assumes the shift clock is slow enough for the sampling clock to see each level.
`timescale 1ns/1ps
module ssm_slave_model
(
   input wire clk_in,
   input wire sck_in,
   input wire sd_in,
   input wire pol_in,
   input wire clr_in,
   output reg [17:0] rx_out,
   output reg [5:0] cnt_out
);
   reg sck_q = 1'b0;
   initial
   begin
      rx_out = 18'h0;
      cnt_out = 6'h0;
   end
   // the slave only listens, so the data line is never driven here.
   always @(posedge clk_in)
   begin
      sck_q <= sck_in;
      if (clr_in)
         cnt_out <= 6'h0;
      // take each bit at the trailing edge, first one lands lowest.
      else if (sck_q != sck_in && sck_in == pol_in)
      begin
         rx_out <= {sd_in, rx_out[17:1]};
         cnt_out <= cnt_out + 6'h1;
      end
   end
endmodule // ssm_slave_model

/* File: test/ssm_port_bench.sv */
// Self-checking bench: registers over the bus, frames into a listening slave.
// Assumes zero-wait answers but still waits on ready at every phase.
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_port_bench;
   reg clk, rst, hsel, hwrite, lk, lk_en, sd_drv, clr, pol, nv;
   reg last_d = 1'b0;
   reg [31:0] haddr, hwdata, rd, seed;
   reg [1:0] htrans;
   reg [7:0] c1, c2, b;
   wire [31:0] hrdata;
   wire hready, hresp, dout, doe, cout, coe, irq;
   wire [17:0] rx;
   wire [5:0] cnt;
   integer errors, n_checks, i, k, nb;
   // With lk_en low, a released data line shows the inverse of its last driven level; with lk_en high it shows sd_drv.
   wire data_w = doe ? dout : (lk_en ? sd_drv : ~last_d);
   wire clock_w = coe ? cout : lk & lk_en;
   ssm_port ssm_port_inst (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .DATA_PIN_IN(data_w), .DATA_PIN_OUT(dout), .DATA_PIN_OE_OUT(doe),
      .CLOCK_PIN_IN(clock_w), .CLOCK_PIN_OUT(cout), .CLOCK_PIN_OE_OUT(coe), .IRQ_OUT(irq));
   ssm_slave_model ssm_slave_model_inst (.clk_in(clk), .sck_in(clock_w), .sd_in(data_w),
      .pol_in(pol), .clr_in(clr), .rx_out(rx), .cnt_out(cnt));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      lk = 1'b0;
      #1;
      forever #32 lk = ~lk;
   end
   always @(posedge clk)
      if (doe)
         last_d <= dout;
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task bus(input wr, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= `SSM_HTRANS_NONSEQ;
         haddr <= a;
         hwrite <= wr;
         @(posedge clk);
         while (hready !== 1'b1)
            @(posedge clk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= d;
         @(posedge clk);
         while (hready !== 1'b1)
            @(posedge clk);
         rd = hrdata;
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d checks %0d", errors, n_checks);
         if (errors == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial
   begin
      #300000;
      errors = errors + 1;
      finish_test;
   end
   initial
   begin
      errors = 0;
      n_checks = 0;
      {rst, hsel, hwrite, lk_en, sd_drv, clr, pol} = 7'h40;
      {haddr, hwdata, htrans} = 66'h0;
      seed = 32'd50151;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `SSM_A_PERIPHERAL_INTERRUPT_FLAG_1, 32'h0);
      check("holding empty", rd & 32'h10, 32'h10);
      bus(1'b1, 32'h24, 32'hff);
      bus(1'b0, 32'h24, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, `SSM_A_DIVLO, 32'h1);
      bus(1'b1, `SSM_A_DIVHI, 32'h0);
      bus(1'b1, `SSM_A_INTCTL, 32'hc0);
      bus(1'b1, `SSM_A_PERIPHERAL_INTERRUPT_ENABLE_1, 32'h10);
      bus(1'b1, `SSM_A_RXCTL, 32'h80);
      for (k = 0; k < 4; k = k + 1)
      begin
         seed = xs(seed);
         {nv, c2, c1} = seed[16:0];
         nb = 8 + k / 2;
         pol <= k[0];
         // rate and polarity first, then mode, then the characters.
         bus(1'b1, `SSM_A_BAUDCTL, {27'h0000000, k[0], 4'h4});
         bus(1'b1, `SSM_A_TXCTL, {1'b1, nb == 9, 5'h18, nv});
         clr <= 1'b1;
         repeat (3) @(posedge clk);
         clr <= 1'b0;
         check("pins", {hresp, coe, doe, cout}, {3'b011, k[0]});
         bus(1'b1, `SSM_A_HOLD, c1);
         bus(1'b1, `SSM_A_HOLD, c2);
         repeat (2) @(posedge clk);
         check("lead", {cout, irq}, {k % 2 == 0, 1'b0});
         i = 0;
         while (cnt < 2 * nb && i < 2000)
         begin
            @(posedge clk);
            i = i + 1;
         end
         repeat (40) @(posedge clk);
         check("clocks", cnt, 2 * nb);
         check("bits", rx >> (18 - 2 * nb), nb == 9 ? {nv, c2, nv, c1} : {c2, c1});
         check("irq", irq, 1'b1);
      end
      bus(1'b1, `SSM_A_INTCTL, 32'h40);
      repeat (2) @(posedge clk);
      check("irq masked", irq, 1'b0);
      b = seed[31:24];
      pol <= 1'b0;
      bus(1'b1, `SSM_A_BAUDCTL, 32'h4);
      bus(1'b1, `SSM_A_RXCTL, 32'h90);
      bus(1'b1, `SSM_A_TXCTL, 32'h10);
      repeat (3) @(posedge clk);
      check("rx oe", {doe, coe}, 2'b00);
      @(negedge lk);
      @(posedge clk);
      lk_en <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
      begin
         @(posedge lk);
         @(posedge clk);
         sd_drv <= b[i];
      end
      @(negedge lk);
      @(posedge clk);
      lk_en <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b0, `SSM_A_HOLD, 32'h0);
      check("slave rx", rd, {24'h0, b});
      finish_test;
   end
endmodule // ssm_port_bench
